// *** logic/sbcspi_consts.svh ***
`ifndef SBCSPI_CONSTS_SVH
`define SBCSPI_CONSTS_SVH

// ************************************************************
// frame layout
// ************************************************************
`define SBCSPI_FRAME_BITS 5'h10
`define SBCSPI_SEL_HI 15
`define SBCSPI_SEL_LO 13
`define SBCSPI_RDONLY_BIT 12
`define SBCSPI_DATA_HI 11
`define SBCSPI_SEL_DONE_CNT 5'h02
`define SBCSPI_HDR_BITS 5'h04

// ************************************************************
// register selects
// ************************************************************
`define SBCSPI_SEL_WDS 3'h0
`define SBCSPI_SEL_MODE 3'h1
`define SBCSPI_SEL_IEN 3'h2
`define SBCSPI_SEL_IST 3'h3

// ************************************************************
// watchdog and status field positions and resets
// ************************************************************
`define SBCSPI_WDMODE_BIT 11
`define SBCSPI_WDP_HI 10
`define SBCSPI_WDP_LO 8
`define SBCSPI_SOFTRST_BIT 7
`define SBCSPI_WDMODE_RST 1'h0
`define SBCSPI_WDP_RST 3'h4
`define SBCSPI_REG_RST 12'h000
`define SBCSPI_RSVD_BITS 3'h0

// ************************************************************
// watchdog period in ms per code
// ************************************************************
`define SBCSPI_WDP_MS_0 13'h0008
`define SBCSPI_WDP_MS_1 13'h0010
`define SBCSPI_WDP_MS_2 13'h0020
`define SBCSPI_WDP_MS_3 13'h0040
`define SBCSPI_WDP_MS_4 13'h0080
`define SBCSPI_WDP_MS_5 13'h0100
`define SBCSPI_WDP_MS_6 13'h0400
`define SBCSPI_WDP_MS_7 13'h1000

// ************************************************************
// host timing in core cycles
// ************************************************************
`define SBCSPI_HOST_HALF_DIV 2
`define SBCSPI_HOST_LEAD_CYC 6
`define SBCSPI_HOST_GAP_CYC 6

`endif

// *** logic/sbcspi_pkg.sv ***
package sbcspi_pkg;
  typedef logic [11:0] sbcspi_data_t;
  typedef logic [15:0] sbcspi_frame_t;
  typedef logic [2:0] sbcspi_period_t;
  typedef logic [12:0] sbcspi_ms_t;
  typedef enum logic [2:0] {
    SBCSPI_WDS = 3'h0,
    SBCSPI_MODE = 3'h1,
    SBCSPI_IEN = 3'h2,
    SBCSPI_IST = 3'h3
  } sbcspi_sel_e;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LEAD = 3'b001,
    HS_HIGH = 3'b010,
    HS_LOW = 3'b011,
    HS_GAP = 3'b100
  } sbcspi_hstate_e;
endpackage

// *** logic/sbcspi_if.sv ***
`timescale 1ns/1ps
// ************************************************************
// four-wire serial link between host and device
// ************************************************************
interface sbcspi_if;
  logic sck;
  logic chip_select_n;
  logic sdi;
  logic sdo;
  logic sdo_en_n;
  logic sdo_line;

  // undriven line is held high by a pull-up
  assign sdo_line = sdo_en_n ? 1'h1 : sdo;

  modport device (
    input sck,
    input chip_select_n,
    input sdi,
    output sdo,
    output sdo_en_n
  );
  modport host (
    output sck,
    output chip_select_n,
    output sdi,
    input sdo_line
  );
endinterface // sbcspi_if

// *** logic/sbcspi_sync.sv ***
`timescale 1ns/1ps
// ************************************************************
// two-flop synchroniser for asynchronous levels
// ************************************************************
module sbcspi_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("sbcspi_sync: WIDTH must be at least 1");
    end
  endgenerate

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else if (en) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sbcspi_sync

// *** logic/sbcspi_device.sv ***
`timescale 1ns/1ps
`include "sbcspi_consts.svh"
// Contract
// (R1) status shifts out while control shifts in
// (R2) read-only access leaves register unchanged
// (R3) chip select low enables transfer participation
// (R4) host idles serial clock low
// (R5) data output released while deselected
// (R6) sample on falling, change on rising
// (R7) frame bits 15..13 select register
// (R8) bit 12 set means read-only access
// (R9) selects 0..3 map the four registers
// (R10) bits 11..0 carry register data
// (R11) watchdog mode bit resets to zero
// (R12) period code maps ms, resets 100
// (R13) bit 7 reads watchdog-disable pin
// (R14) writing 1 to bit 7 resets software
// (R15) bit 6 reports main regulator low
// (R16) bit 5 reports CAN regulator low
// (R17) bit 4 reports wake input one
// (R18) bit 3 reports wake input two
// (R19) sixteen bits MSB first, commit on deselect
module sbcspi_device (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // serial link
  sbcspi_if.device link,
  // asynchronous status inputs
  input wire logic watchdog_disable_pin,
  input wire logic main_regulator_low,
  input wire logic can_regulator_low,
  input wire logic local_wake_input_one,
  input wire logic local_wake_input_two,
  // watchdog controls
  output logic watchdog_mode_select,
  output sbcspi_pkg::sbcspi_period_t watchdog_period_code,
  output sbcspi_pkg::sbcspi_ms_t watchdog_period_ms,
  output logic soft_reset_pulse,
  // other control and status registers
  output sbcspi_pkg::sbcspi_data_t operating_mode_control,
  output sbcspi_pkg::sbcspi_data_t interrupt_enable_control,
  output sbcspi_pkg::sbcspi_data_t interrupt_event_status,
  // write frame to a mapped register taken
  output logic write_done_pulse
);
  import sbcspi_pkg::*;

  // ************************************************************
  // link domain: receive on falling edge
  // ************************************************************
  sbcspi_frame_t rx_shift;
  logic [4:0] fall_cnt;
  logic [2:0] rx_addr;
  logic started;
  wire logic [4:0] next_fall_cnt;

  // count restarts at the first fall of each frame
  assign next_fall_cnt = !started ? 5'h01 :
                         (fall_cnt == 5'h1f) ? fall_cnt : fall_cnt + 5'h01;

  // frame start flag, cleared whenever chip select is high
  always_ff @(negedge link.sck or posedge link.chip_select_n or negedge rst_b) begin
    if (!rst_b) begin
      started <= 1'h0;
    end else if (link.chip_select_n) begin
      started <= 1'h0; // R3
    end else begin
      started <= 1'h1;
    end
  end

  // shift in msb first; held after the frame for the core side
  always_ff @(negedge link.sck or negedge rst_b) begin
    if (!rst_b) begin
      rx_shift <= '0;
      fall_cnt <= 5'h00;
      rx_addr <= 3'h0;
    end else if (!link.chip_select_n) begin // R3
      rx_shift <= {rx_shift[14:0], link.sdi}; // R6 R19
      fall_cnt <= next_fall_cnt;
      if (started && fall_cnt == `SBCSPI_SEL_DONE_CNT) begin
        rx_addr <= {rx_shift[1:0], link.sdi}; // R7
      end
    end
  end

  // ************************************************************
  // link domain: transmit on rising edge
  // ************************************************************
  sbcspi_data_t snap [0:3];
  logic [3:0] snap_hdr;
  wire logic [4:0] tx_k;
  wire logic [3:0] tx_idx;
  wire logic [1:0] hdr_idx;
  wire sbcspi_data_t tx_word;
  wire logic next_sdo;

  // bits already sampled in this frame pick the outgoing bit
  assign tx_k = started ? fall_cnt : 5'h00;
  assign tx_idx = 4'hf - tx_k[3:0];
  assign hdr_idx = 2'h3 - tx_k[1:0];
  assign tx_word = rx_addr[2] ? `SBCSPI_REG_RST : snap[rx_addr[1:0]]; // R9
  assign next_sdo = (tx_k < `SBCSPI_HDR_BITS) ? snap_hdr[hdr_idx] :
                    (tx_k < `SBCSPI_FRAME_BITS) ? tx_word[tx_idx] : 1'h0; // R1 R10

  // drive only while selected
  always_ff @(posedge link.sck or posedge link.chip_select_n or negedge rst_b) begin
    if (!rst_b) begin
      link.sdo <= 1'h0;
      link.sdo_en_n <= 1'h1;
    end else if (link.chip_select_n) begin
      link.sdo <= 1'h0;
      link.sdo_en_n <= 1'h1; // R5
    end else begin
      link.sdo <= next_sdo; // R6
      link.sdo_en_n <= 1'h0;
    end
  end

  // ************************************************************
  // core domain: synchronised pins
  // ************************************************************
  logic cs_s;
  logic wd_disable_s;
  logic main_low_s;
  logic can_low_s;
  logic wake_one_s;
  logic wake_two_s;
  logic cs_prev;

  sbcspi_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk(core_clk),
    .rst_b(rst_b),
    .en(clk_en),
    .d({link.chip_select_n, watchdog_disable_pin, main_regulator_low,
        can_regulator_low, local_wake_input_one, local_wake_input_two}),
    .q({cs_s, wd_disable_s, main_low_s, can_low_s, wake_one_s, wake_two_s})
  );

  // ************************************************************
  // core domain: frame commit decode
  // ************************************************************
  wire logic cs_rise;
  wire logic frame_ok;
  wire logic wr_en;
  wire logic [2:0] wr_sel;
  wire sbcspi_data_t wr_data;
  wire logic wr_wds;
  wire sbcspi_data_t wds_word;

  // link-side words are quiet once chip select is high
  assign cs_rise = cs_s && !cs_prev;
  assign frame_ok = cs_rise && (fall_cnt == `SBCSPI_FRAME_BITS); // R19
  assign wr_sel = rx_shift[`SBCSPI_SEL_HI:`SBCSPI_SEL_LO]; // R7
  assign wr_data = rx_shift[`SBCSPI_DATA_HI:0]; // R10
  assign wr_en = frame_ok && !rx_shift[`SBCSPI_RDONLY_BIT] && !wr_sel[2]; // R2 R8 R9
  assign wr_wds = wr_en && (wr_sel == `SBCSPI_SEL_WDS);
  assign wds_word = {watchdog_mode_select, watchdog_period_code,
                     wd_disable_s, // R13
                     main_low_s, // R15
                     can_low_s, // R16
                     wake_one_s, // R17
                     wake_two_s, // R18
                     `SBCSPI_RSVD_BITS};

  // edge detect and one-cycle pulses
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_prev <= 1'h1;
      soft_reset_pulse <= 1'h0;
      write_done_pulse <= 1'h0;
    end else if (clk_en) begin
      cs_prev <= cs_s;
      soft_reset_pulse <= wr_wds && wr_data[`SBCSPI_SOFTRST_BIT]; // R14
      write_done_pulse <= wr_en;
    end
  end

  // ************************************************************
  // core domain: register storage
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_mode_select <= `SBCSPI_WDMODE_RST; // R11
      watchdog_period_code <= `SBCSPI_WDP_RST; // R12
      operating_mode_control <= `SBCSPI_REG_RST;
      interrupt_enable_control <= `SBCSPI_REG_RST;
      interrupt_event_status <= `SBCSPI_REG_RST;
    end else if (clk_en) begin
      if (soft_reset_pulse) begin
        watchdog_mode_select <= `SBCSPI_WDMODE_RST; // R11
        watchdog_period_code <= `SBCSPI_WDP_RST; // R12
        operating_mode_control <= `SBCSPI_REG_RST;
        interrupt_enable_control <= `SBCSPI_REG_RST;
        interrupt_event_status <= `SBCSPI_REG_RST;
      end else if (wr_en) begin
        unique case (wr_sel)
          `SBCSPI_SEL_WDS: begin
            watchdog_mode_select <= wr_data[`SBCSPI_WDMODE_BIT]; // R11
            watchdog_period_code <= wr_data[`SBCSPI_WDP_HI:`SBCSPI_WDP_LO]; // R12
          end
          `SBCSPI_SEL_MODE: begin
            operating_mode_control <= wr_data;
          end
          `SBCSPI_SEL_IEN: begin
            interrupt_enable_control <= wr_data;
          end
          default: begin
            interrupt_event_status <= wr_data;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // core domain: period decode
  // ************************************************************
  wire sbcspi_ms_t next_period_ms;

  assign next_period_ms =
    (watchdog_period_code == 3'h0) ? `SBCSPI_WDP_MS_0 :
    (watchdog_period_code == 3'h1) ? `SBCSPI_WDP_MS_1 :
    (watchdog_period_code == 3'h2) ? `SBCSPI_WDP_MS_2 :
    (watchdog_period_code == 3'h3) ? `SBCSPI_WDP_MS_3 :
    (watchdog_period_code == 3'h4) ? `SBCSPI_WDP_MS_4 :
    (watchdog_period_code == 3'h5) ? `SBCSPI_WDP_MS_5 :
    (watchdog_period_code == 3'h6) ? `SBCSPI_WDP_MS_6 : `SBCSPI_WDP_MS_7; // R12

  // registered so the output comes from a flop
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_period_ms <= `SBCSPI_WDP_MS_4;
    end else if (clk_en) begin
      watchdog_period_ms <= next_period_ms;
    end
  end

  // ************************************************************
  // core domain: readback snapshot, refreshed between frames
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      snap[0] <= `SBCSPI_REG_RST;
      snap[1] <= `SBCSPI_REG_RST;
      snap[2] <= `SBCSPI_REG_RST;
      snap[3] <= `SBCSPI_REG_RST;
      snap_hdr <= 4'h0;
    end else if (clk_en && cs_s) begin
      snap[0] <= wds_word; // R13
      snap[1] <= operating_mode_control;
      snap[2] <= interrupt_enable_control;
      snap[3] <= interrupt_event_status;
      if (frame_ok) begin
        snap_hdr <= rx_shift[15:12];
      end
    end
  end
endmodule // sbcspi_device

// *** logic/sbcspi_host.sv ***
`timescale 1ns/1ps
`include "sbcspi_consts.svh"
// ************************************************************
// serial master: makes the link clock from core_clk
// ************************************************************
module sbcspi_host #(
  parameter int HALF_DIV = `SBCSPI_HOST_HALF_DIV,
  parameter int LEAD_CYC = `SBCSPI_HOST_LEAD_CYC,
  parameter int GAP_CYC = `SBCSPI_HOST_GAP_CYC
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // serial link
  sbcspi_if.host link,
  // request
  input wire logic req_valid,
  output logic req_ready,
  input wire sbcspi_pkg::sbcspi_sel_e req_select,
  input wire logic req_readonly,
  input wire sbcspi_pkg::sbcspi_data_t req_data,
  // answer
  output logic rsp_valid,
  output sbcspi_pkg::sbcspi_frame_t rsp_data
);
  import sbcspi_pkg::*;

  generate
    if (HALF_DIV < 2 || HALF_DIV > 255 || LEAD_CYC < 4 || LEAD_CYC > 255 ||
        GAP_CYC < 4 || GAP_CYC > 255) begin : g_chk
      $error("sbcspi_host: timing parameters out of range");
    end
  endgenerate

  sbcspi_hstate_e state;
  logic [7:0] tmr;
  logic [3:0] bitn;
  sbcspi_frame_t tx_word;
  sbcspi_frame_t rx_word;
  logic sdo_s;
  wire logic tmr_done;
  wire sbcspi_frame_t next_rx;

  // sampled data line crosses into core_clk
  sbcspi_sync #(
    .WIDTH(1)
  ) u_sdo_sync (
    .clk(core_clk),
    .rst_b(rst_b),
    .en(clk_en),
    .d(link.sdo_line),
    .q(sdo_s)
  );

  assign tmr_done = (tmr == 8'h00);
  assign next_rx = {rx_word[14:0], sdo_s}; // R19

  // frame sequencer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= HS_IDLE;
      tmr <= 8'h00;
      bitn <= 4'h0;
      tx_word <= '0;
      rx_word <= '0;
      link.sck <= 1'h0; // R4
      link.chip_select_n <= 1'h1; // R3
      link.sdi <= 1'h0;
      req_ready <= 1'h0;
      rsp_valid <= 1'h0;
      rsp_data <= '0;
    end else if (clk_en) begin
      rsp_valid <= 1'h0;
      unique case (state)
        HS_IDLE: begin
          req_ready <= 1'h1;
          if (req_valid && req_ready) begin
            req_ready <= 1'h0;
            tx_word <= {req_select, req_readonly, req_data}; // R7 R8
            link.chip_select_n <= 1'h0; // R3
            tmr <= 8'(LEAD_CYC - 1);
            state <= HS_LEAD;
          end
        end
        HS_LEAD: begin
          tmr <= tmr - 8'h01;
          if (tmr_done) begin
            link.sck <= 1'h1; // R6
            link.sdi <= tx_word[15];
            tx_word <= {tx_word[14:0], 1'h0};
            bitn <= 4'h0;
            tmr <= 8'(HALF_DIV - 1);
            state <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          tmr <= tmr - 8'h01;
          if (tmr_done) begin
            link.sck <= 1'h0; // R6
            tmr <= 8'(HALF_DIV - 1);
            state <= HS_LOW;
          end
        end
        HS_LOW: begin
          tmr <= tmr - 8'h01;
          if (tmr_done) begin
            rx_word <= next_rx; // R6
            if (bitn == 4'hf) begin
              link.chip_select_n <= 1'h1; // R19
              rsp_valid <= 1'h1;
              rsp_data <= next_rx; // R1
              tmr <= 8'(GAP_CYC - 1);
              state <= HS_GAP;
            end else begin
              bitn <= bitn + 4'h1;
              link.sck <= 1'h1;
              link.sdi <= tx_word[15];
              tx_word <= {tx_word[14:0], 1'h0};
              tmr <= 8'(HALF_DIV - 1);
              state <= HS_HIGH;
            end
          end
        end
        default: begin
          tmr <= tmr - 8'h01;
          if (tmr_done) begin
            state <= HS_IDLE;
          end
        end
      endcase
    end
  end
endmodule // sbcspi_host

// *** verification/sbcspi_chk.sv ***
`timescale 1ns/1ps
// ************************************************************
// link protocol checker
// ************************************************************
module sbcspi_chk (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // serial link
  input wire logic sck,
  input wire logic chip_select_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_en_n,
  input wire logic sdo_line
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  logic sck_q;
  logic [4:0] rise_cnt;

  // count link clock rises inside a frame
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_q <= 1'h0;
      rise_cnt <= 5'h00;
    end else begin
      sck_q <= sck;
      rise_cnt <= chip_select_n ? 5'h00 : rise_cnt + {4'h0, sck & ~sck_q};
    end
  end

  // frame setup and gap spacing
  sequence s_lead;
    (!sck)[*4];
  endsequence
  sequence s_gap;
    chip_select_n[*4];
  endsequence

  property p_sdo_released;
    chip_select_n |-> sdo_en_n;
  endproperty
  a_sdo_released: assert property (p_sdo_released)
    else $error("data output driven while deselected");
  property p_line_pulled;
    $rose(chip_select_n) |-> $rose(sdo_en_n) && sdo_line;
  endproperty
  a_line_pulled: assert property (p_line_pulled)
    else $error("released data line not high");
  property p_sck_idle;
    chip_select_n |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("link clock not idle low outside a frame");
  property p_cs_change;
    $changed(chip_select_n) |-> !sck && !$past(sck);
  endproperty
  a_cs_change: assert property (p_cs_change)
    else $error("select changed while link clock high");
  property p_sdi_on_rise;
    $changed(sdi) && !chip_select_n |-> $rose(sck);
  endproperty
  a_sdi_on_rise: assert property (p_sdi_on_rise)
    else $error("host data changed off the rising edge");
  property p_sdo_on_rise;
    $changed(sdo) && !sdo_en_n |-> $rose(sck);
  endproperty
  a_sdo_on_rise: assert property (p_sdo_on_rise)
    else $error("device data changed off the rising edge");
  property p_first_drive;
    $rose(sck) && !chip_select_n |-> !sdo_en_n;
  endproperty
  a_first_drive: assert property (p_first_drive)
    else $error("device not driving during frame");
  property p_frame_len;
    $rose(chip_select_n) |-> rise_cnt == 5'h10;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame not sixteen clocks long");
  property p_lead;
    $fell(chip_select_n) |-> s_lead;
  endproperty
  a_lead: assert property (p_lead)
    else $error("link clock rose too soon after select");
  property p_gap;
    $rose(chip_select_n) |-> s_gap;
  endproperty
  a_gap: assert property (p_gap)
    else $error("frames too close together");
endmodule // sbcspi_chk

// *** verification/sbc_spi_status_regs_tb.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
// ************************************************************
// host and device joined over the link
// ************************************************************
module sbc_spi_status_regs_tb;
  import sbcspi_pkg::*;
  logic core_clk, rst_b, req_valid, req_ready, req_readonly, rsp_valid;
  logic wd_dis, main_low, can_low, wake_one, wake_two, wd_mode, srst, wdone;
  sbcspi_sel_e req_select;
  sbcspi_data_t req_data, opm, ien, ist;
  sbcspi_frame_t rsp_data, rsp_q;
  sbcspi_period_t code;
  sbcspi_ms_t ms;
  int bad_count, samples_checked, cycles, dones, srsts;
  sbcspi_ms_t ms_tab [8] = '{13'h0008, 13'h0010, 13'h0020, 13'h0040,
                             13'h0080, 13'h0100, 13'h0400, 13'h1000};

  sbcspi_if link_if ();
  sbcspi_host u_sbcspi_host (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'h1),
    .link(link_if), .req_valid(req_valid), .req_ready(req_ready),
    .req_select(req_select), .req_readonly(req_readonly), .req_data(req_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  sbcspi_device u_sbcspi_device (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'h1),
    .link(link_if), .watchdog_disable_pin(wd_dis), .main_regulator_low(main_low),
    .can_regulator_low(can_low), .local_wake_input_one(wake_one),
    .local_wake_input_two(wake_two), .watchdog_mode_select(wd_mode),
    .watchdog_period_code(code), .watchdog_period_ms(ms), .soft_reset_pulse(srst),
    .operating_mode_control(opm), .interrupt_enable_control(ien),
    .interrupt_event_status(ist), .write_done_pulse(wdone));
  sbcspi_chk u_sbcspi_chk (.core_clk(core_clk), .rst_b(rst_b), .sck(link_if.sck),
    .chip_select_n(link_if.chip_select_n), .sdi(link_if.sdi), .sdo(link_if.sdo),
    .sdo_en_n(link_if.sdo_en_n), .sdo_line(link_if.sdo_line));

  // core clock and hang guard
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one frame through the host, then count core pulses
  task automatic frame(input sbcspi_sel_e sel, input logic ro, input sbcspi_data_t d);
    req_valid <= 1'h1;
    req_select <= sel;
    req_readonly <= ro;
    req_data <= d;
    @(posedge core_clk);
    while (req_ready !== 1'h1) @(posedge core_clk);
    req_valid <= 1'h0;
    while (rsp_valid !== 1'h1) @(posedge core_clk);
    rsp_q = rsp_data;
    dones = 0;
    srsts = 0;
    repeat (10) begin
      @(posedge core_clk);
      dones += (wdone === 1'h1);
      srsts += (srst === 1'h1);
    end
  endtask

  task automatic t_reset_values();
    `CHK(wd_mode, 1'h0)
    `CHK(code, 3'h4)
    `CHK(ms, 13'h0080)
    `CHK({opm, ien, ist}, 36'h0)
  endtask

  // status bits in both polarities, read only
  task automatic t_status();
    {wd_dis, main_low, can_low, wake_one, wake_two} <= 5'h16;
    repeat (6) @(posedge core_clk);
    frame(SBCSPI_WDS, 1'h1, 12'hfff);
    `CHK(rsp_q, 16'h04b0)
    `CHK(dones, 0)
    `CHK(srsts, 0)
    `CHK(code, 3'h4)
    {wd_dis, main_low, can_low, wake_one, wake_two} <= 5'h09;
    repeat (6) @(posedge core_clk);
    frame(SBCSPI_WDS, 1'h1, 12'h000);
    `CHK(rsp_q, 16'h1448)
  endtask

  // write, then read-only access with other data
  task automatic t_reg_write();
    sbcspi_data_t d;
    sbcspi_sel_e s;
    for (int i = 1; i < 4; i++) begin
      s = sbcspi_sel_e'(i[2:0]);
      d = 12'ha5c ^ {i[3:0], i[3:0], 4'h0};
      frame(s, 1'h0, d);
      `CHK(dones, 1)
      frame(s, 1'h1, ~d);
      `CHK(rsp_q, {s, 1'h0, d})
      `CHK(dones, 0)
      `CHK((i == 1) ? opm : (i == 2) ? ien : ist, d)
    end
  endtask

  // unmapped select: never written, reads zero data
  task automatic t_unmapped();
    frame(sbcspi_sel_e'(3'h5), 1'h0, 12'hfff);
    `CHK(dones, 0)
    `CHK(srsts, 0)
    `CHK({opm, ien, ist}, 36'hb4c87c96c)
    frame(sbcspi_sel_e'(3'h5), 1'h1, 12'h000);
    `CHK(rsp_q, 16'ha000)
  endtask

  // every period code and its time
  task automatic t_period();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      frame(SBCSPI_WDS, 1'h0, {1'h1, c, 8'h00});
      `CHK(code, c)
      `CHK(ms, ms_tab[i])
      `CHK(wd_mode, 1'h1)
    end
  endtask

  // software reset returns registers to defaults
  task automatic t_soft_reset();
    frame(SBCSPI_WDS, 1'h0, 12'h280);
    `CHK(srsts, 1)
    `CHK({wd_mode, code}, 4'h4)
    `CHK(opm, 12'h000)
  endtask

  // reset, then the scenarios
  initial begin
    core_clk = 1'h0;
    rst_b = 1'h0;
    req_valid = 1'h0;
    req_select = SBCSPI_WDS;
    req_readonly = 1'h0;
    req_data = 12'h000;
    {wd_dis, main_low, can_low, wake_one, wake_two} = 5'h00;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge core_clk);
    t_reset_values();
    t_status();
    t_reg_write();
    t_unmapped();
    t_period();
    t_soft_reset();
    final_report();
  end
endmodule // sbc_spi_status_regs_tb
